/* logic/jis_pkg.sv */
// Purpose: shared constants and types of the test-port status and security block
// Assumes: 32-bit AHB-Lite register bus, 8-bit instruction register
// Notes: offsets are byte addresses of aligned words
package jis_pkg;
  // register offsets
  localparam logic [7:0] JIS_OFS_SECURE = 8'h00;
  localparam logic [7:0] JIS_OFS_PROT = 8'h04;
  localparam logic [7:0] JIS_OFS_STATUS = 8'h08;
  localparam logic [7:0] JIS_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] JIS_OFS_IRQ_MASK = 8'h10;
  // reset values
  localparam logic JIS_RST_SECURE = 1'h0;
  localparam logic [31:0] JIS_RST_PROT = 32'h00000000;
  localparam logic [3:0] JIS_RST_IRQ_MASK = 4'h0;
  // status field positions
  localparam int JIS_ST_EXT_EN = 0;
  localparam int JIS_ST_OPEN_DRAIN = 1;
  localparam int JIS_ST_ERR = 2;
  localparam int JIS_ST_BUSY = 3;
  localparam int JIS_ST_ACTIVE = 4;
  // interrupt event positions
  localparam int JIS_EV_ERR = 0;
  localparam int JIS_EV_REFUSED = 1;
  localparam int JIS_EV_CHIP_ERASED = 2;
  localparam int JIS_EV_OP_DONE = 3;
  localparam int JIS_EV_N = 4;
  // enable-command option bits in the data register
  localparam int JIS_OPT_EXT_EN = 0;
  localparam int JIS_OPT_OPEN_DRAIN = 1;
  // instruction codes
  localparam logic [7:0] JIS_IR_CONFIG_ENABLE = 8'h0C;
  localparam logic [7:0] JIS_IR_CONFIG_DISABLE = 8'h0F;
  localparam logic [7:0] JIS_IR_ERROR_CLEAR = 8'h20;
  localparam logic [7:0] JIS_IR_PROGRAM = 8'h21;
  localparam logic [7:0] JIS_IR_SECTOR_ERASE = 8'h22;
  localparam logic [7:0] JIS_IR_VERIFY = 8'h23;
  localparam logic [7:0] JIS_IR_CHIP_ERASE = 8'h24;
  localparam logic [7:0] JIS_IR_BYPASS = 8'hFF;
  localparam logic [7:0] JIS_IR_CAPTURE = 8'h01;
  // flash operation codes
  typedef enum logic [1:0] {
    JIS_OP_PROGRAM = 2'h0,
    JIS_OP_SECTOR_ERASE = 2'h1,
    JIS_OP_CHIP_ERASE = 2'h2
  } jis_op_type;
  // request to the flash controller
  typedef struct packed {
    jis_op_type op;
    logic [4:0] sector;
    logic [15:0] data;
  } jis_flash_req_type;
endpackage : jis_pkg

/* logic/jis_status_security.sv */
// Purpose: test-port extension with status pins, security lockout and sector protection
// Assumes: tck, tms, tdi and chip_reset_n come from pins; flash controller runs on hclk
// Notes: tck is sampled by hclk and must stay well below hclk / 4
`timescale 1ns/1ps
`default_nettype none
module jis_status_security
  import jis_pkg::*;
#(
  parameter int NUM_SECTORS = 8,
  parameter int DR_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe,
  // status pins
  output logic isc_ready_busy_pin_o,
  output logic isc_ready_busy_pin_oe,
  output logic isc_error_pin_o,
  output logic isc_error_pin_oe,
  input wire logic chip_reset_n,
  // flash controller
  output logic flash_req_valid,
  output jis_flash_req_type flash_req,
  input wire logic flash_busy,
  input wire logic flash_sec_write,
  input wire logic flash_done,
  input wire logic flash_error,
  input wire logic [DR_W-1:0] flash_rdata
);
  initial begin
    if (NUM_SECTORS < 1 || NUM_SECTORS > 32 || DR_W < 8) begin
      $error("jis_status_security: unsupported parameters");
    end
  end

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } jis_tap_type;

  // pin synchronisers
  logic [2:0] tck_s;
  logic [1:0] tms_s, tdi_s;
  logic [2:0] crst_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_s <= 3'h0;
      tms_s <= 2'h3;
      tdi_s <= 2'h3;
      crst_s <= 3'h7;
    end else begin
      tck_s <= {tck_s[1:0], tck};
      tms_s <= {tms_s[0], tms};
      tdi_s <= {tdi_s[0], tdi};
      crst_s <= {crst_s[1:0], chip_reset_n};
    end
  end
  logic tck_rise, tck_fall, chip_rst_pulse;
  assign tck_rise = tck_s[1] & ~tck_s[2];
  assign tck_fall = ~tck_s[1] & tck_s[2];
  assign chip_rst_pulse = ~crst_s[1] & crst_s[2];

  // tap controller
  jis_tap_type tap, next_tap;
  always_comb begin
    next_tap = tap;
    case (tap)
      TAP_RESET: next_tap = tms_s[1] ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tap = tms_s[1] ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms_s[1] ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms_s[1] ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_tap = tms_s[1] ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = tms_s[1] ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_tap = tms_s[1] ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_tap = tms_s[1] ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = tms_s[1] ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms_s[1] ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms_s[1] ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_tap = tms_s[1] ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = tms_s[1] ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_tap = tms_s[1] ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_tap = tms_s[1] ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = tms_s[1] ? TAP_SEL_DR : TAP_IDLE;
      default: next_tap = TAP_RESET;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap <= TAP_RESET;
    end else if (tck_rise) begin
      tap <= next_tap;
    end
  end

  // state shared with the command logic
  logic [7:0] ir, ir_sh;
  logic [DR_W-1:0] dr;
  logic isc_active, ext_en, open_drain, disable_seen, err_flag, op_busy, secure;
  logic [NUM_SECTORS-1:0] prot;
  jis_op_type cur_op;
  logic [4:0] dr_sector;
  logic [DR_W-1:0] capture_val;
  assign dr_sector = dr[4:0];
  always_comb begin
    capture_val = '0;
    if (ir == JIS_IR_VERIFY) begin
      capture_val = secure ? '0 : flash_rdata;
    end else begin
      capture_val[JIS_ST_EXT_EN] = ext_en;
      capture_val[JIS_ST_OPEN_DRAIN] = open_drain;
      capture_val[JIS_ST_ERR] = err_flag;
      capture_val[JIS_ST_BUSY] = op_busy | flash_busy;
      capture_val[JIS_ST_ACTIVE] = secure;
    end
  end

  // instruction and data shift registers
  logic capture_evt;
  assign capture_evt = tck_rise && tap == TAP_CAP_DR;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir <= JIS_IR_BYPASS;
      ir_sh <= JIS_IR_CAPTURE;
      dr <= '0;
    end else if (tck_rise) begin
      case (tap)
        TAP_RESET: ir <= JIS_IR_BYPASS;
        TAP_CAP_IR: ir_sh <= JIS_IR_CAPTURE;
        TAP_SH_IR: ir_sh <= {tdi_s[1], ir_sh[7:1]};
        TAP_UPD_IR: ir <= ir_sh;
        TAP_CAP_DR: dr <= capture_val;
        TAP_SH_DR: dr <= (ir == JIS_IR_BYPASS) ? {{(DR_W-1){1'b0}}, tdi_s[1]} : {tdi_s[1], dr[DR_W-1:1]};
        default: ir <= ir;
      endcase
    end
  end

  // serial data output, changes on falling tck; enable also drops on any hclk while the port is inactive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= (tap == TAP_SH_IR) ? ir_sh[0] : dr[0];
      tdo_oe <= isc_active && (tap == TAP_SH_IR || tap == TAP_SH_DR);
    end else if (!isc_active) begin
      tdo_oe <= 1'b0;
    end
  end

  // command decode at update-dr
  logic exec_evt, is_flash_cmd, refuse, accept;
  logic sector_ok;
  logic [31:0] prot_ext;
  assign sector_ok = 6'(dr_sector) < 6'(NUM_SECTORS);
  assign prot_ext = 32'(prot);
  assign exec_evt = tck_rise && tap == TAP_UPD_DR;
  assign is_flash_cmd = ir == JIS_IR_PROGRAM || ir == JIS_IR_SECTOR_ERASE || ir == JIS_IR_CHIP_ERASE;
  always_comb begin
    refuse = 1'b0;
    if (exec_evt && (is_flash_cmd || ir == JIS_IR_VERIFY)) begin
      if (!isc_active || op_busy || flash_busy) begin
        refuse = 1'b1;
      end else if (secure && ir != JIS_IR_CHIP_ERASE) begin
        refuse = 1'b1;
      end else if (ir == JIS_IR_SECTOR_ERASE) begin
        refuse = !sector_ok || prot_ext[dr_sector];
      end
    end
  end
  assign accept = exec_evt && is_flash_cmd && !refuse;

  // port configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isc_active <= 1'b0;
      ext_en <= 1'b0;
      open_drain <= 1'b0;
      disable_seen <= 1'b0;
    end else if (exec_evt && ir == JIS_IR_CONFIG_ENABLE) begin
      isc_active <= 1'b1;
      ext_en <= dr[JIS_OPT_EXT_EN];
      open_drain <= dr[JIS_OPT_OPEN_DRAIN];
      disable_seen <= 1'b0;
    end else if (exec_evt && ir == JIS_IR_CONFIG_DISABLE) begin
      isc_active <= 1'b0;
      ext_en <= 1'b0;
      disable_seen <= 1'b1;
    end else if (chip_rst_pulse) begin
      disable_seen <= 1'b0;
    end
  end

  // flash requests and completion
  logic chip_erased;
  assign chip_erased = flash_done && op_busy && cur_op == JIS_OP_CHIP_ERASE && !flash_error;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_req_valid <= 1'b0;
      flash_req <= '0;
      op_busy <= 1'b0;
      cur_op <= JIS_OP_PROGRAM;
    end else begin
      flash_req_valid <= accept;
      if (accept) begin
        flash_req.op <= (ir == JIS_IR_PROGRAM) ? JIS_OP_PROGRAM :
                        (ir == JIS_IR_SECTOR_ERASE) ? JIS_OP_SECTOR_ERASE : JIS_OP_CHIP_ERASE;
        flash_req.sector <= dr_sector;
        flash_req.data <= 16'(dr);
        cur_op <= (ir == JIS_IR_PROGRAM) ? JIS_OP_PROGRAM :
                  (ir == JIS_IR_SECTOR_ERASE) ? JIS_OP_SECTOR_ERASE : JIS_OP_CHIP_ERASE;
        op_busy <= 1'b1;
      end else if (flash_done) begin
        op_busy <= 1'b0;
      end
    end
  end

  // sticky error flag, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_flag <= 1'b0;
    end else if (flash_error) begin
      err_flag <= 1'b1;
    end else if ((exec_evt && ir == JIS_IR_ERROR_CLEAR) || (chip_rst_pulse && disable_seen)) begin
      err_flag <= 1'b0;
    end
  end

  // status pins
  logic rdy_val;
  assign rdy_val = !(flash_busy || flash_sec_write || op_busy);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isc_ready_busy_pin_o <= 1'b0;
      isc_ready_busy_pin_oe <= 1'b0;
      isc_error_pin_o <= 1'b0;
      isc_error_pin_oe <= 1'b0;
    end else if (!ext_en) begin
      isc_ready_busy_pin_oe <= 1'b0;
      isc_error_pin_oe <= 1'b0;
      isc_ready_busy_pin_o <= 1'b0;
      isc_error_pin_o <= 1'b0;
    end else if (open_drain) begin
      isc_ready_busy_pin_o <= 1'b0;
      isc_ready_busy_pin_oe <= !rdy_val;
      isc_error_pin_o <= 1'b0;
      isc_error_pin_oe <= err_flag;
    end else begin
      isc_ready_busy_pin_o <= rdy_val;
      isc_ready_busy_pin_oe <= 1'b1;
      isc_error_pin_o <= !err_flag;
      isc_error_pin_oe <= 1'b1;
    end
  end

  // ahb-lite slave
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok, rd_stat;
  logic [JIS_EV_N-1:0] irq_stat, irq_mask, events;
  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_stat = addr_ok && !hwrite && haddr[7:0] == JIS_OFS_IRQ_STAT;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        if (haddr[7:0] == JIS_OFS_SECURE) begin
          hrdata <= {31'h0, secure};
        end else if (haddr[7:0] == JIS_OFS_PROT) begin
          hrdata <= 32'(prot);
        end else if (haddr[7:0] == JIS_OFS_STATUS) begin
          hrdata <= {27'h0, secure, op_busy | flash_busy, err_flag, open_drain, ext_en};
        end else if (haddr[7:0] == JIS_OFS_IRQ_STAT) begin
          hrdata <= 32'(irq_stat);
        end else if (haddr[7:0] == JIS_OFS_IRQ_MASK) begin
          hrdata <= 32'(irq_mask);
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  // security and protection bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      secure <= JIS_RST_SECURE;
      prot <= JIS_RST_PROT[NUM_SECTORS-1:0];
      irq_mask <= JIS_RST_IRQ_MASK;
    end else if (chip_erased) begin
      secure <= 1'b0;
      prot <= '0;
    end else if (wr_pend) begin
      if (wr_addr == JIS_OFS_SECURE) begin
        secure <= hwdata[0];
      end else if (wr_addr == JIS_OFS_PROT) begin
        prot <= hwdata[NUM_SECTORS-1:0];
      end else if (wr_addr == JIS_OFS_IRQ_MASK) begin
        irq_mask <= hwdata[JIS_EV_N-1:0];
      end
    end
  end

  // interrupt status, read clears, set wins
  assign events = {flash_done && op_busy, chip_erased, refuse, flash_error};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (rd_stat ? '0 : irq_stat) | events;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // checks
  sequence s_upd_dr(logic [7:0] code);
    exec_evt && ir == code;
  endsequence
  sequence s_released;
    !isc_ready_busy_pin_oe && !isc_error_pin_oe;
  endsequence
  property p_released;
    @(posedge hclk) disable iff (!hresetn) !ext_en |=> s_released;
  endproperty
  a_released: assert property (p_released) else $error("status pins driven while disabled");
  property p_err_low;
    @(posedge hclk) disable iff (!hresetn) flash_error ##1 (ext_en && !open_drain) |=> !isc_error_pin_o;
  endproperty
  a_err_low: assert property (p_err_low) else $error("error pin not low after flash error");
  property p_err_hold;
    @(posedge hclk) disable iff (!hresetn)
      err_flag && !(exec_evt && ir == JIS_IR_ERROR_CLEAR) && !(chip_rst_pulse && disable_seen) |=> err_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped without clear");
  property p_clear;
    @(posedge hclk) disable iff (!hresetn) s_upd_dr(JIS_IR_ERROR_CLEAR) ##0 !flash_error |=> !err_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("error flag kept after clear");
  property p_busy_low;
    @(posedge hclk) disable iff (!hresetn) (flash_busy || flash_sec_write) && ext_en && !open_drain
      |=> !isc_ready_busy_pin_o;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("ready pin high while busy");
  property p_ready_high;
    @(posedge hclk) disable iff (!hresetn) rdy_val && ext_en && !open_drain |=> isc_ready_busy_pin_o;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("ready pin low while idle");
  property p_open_drain;
    @(posedge hclk) disable iff (!hresetn) ext_en && open_drain |=> !isc_ready_busy_pin_o && !isc_error_pin_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");
  property p_no_readout;
    @(posedge hclk) disable iff (!hresetn) capture_evt && secure && ir == JIS_IR_VERIFY |=> dr == '0;
  endproperty
  a_no_readout: assert property (p_no_readout) else $error("readout while secured");
  property p_secure_block;
    @(posedge hclk) disable iff (!hresetn) exec_evt && secure && ir != JIS_IR_CHIP_ERASE |=> !flash_req_valid;
  endproperty
  a_secure_block: assert property (p_secure_block) else $error("command passed while secured");
  property p_unsecure;
    @(posedge hclk) disable iff (!hresetn) chip_erased |=> !secure && prot == '0;
  endproperty
  a_unsecure: assert property (p_unsecure) else $error("chip erase left device secured");
  property p_protect;
    @(posedge hclk) disable iff (!hresetn)
      exec_evt && ir == JIS_IR_SECTOR_ERASE && sector_ok && prot_ext[dr_sector] |=> !flash_req_valid;
  endproperty
  a_protect: assert property (p_protect) else $error("protected sector erase accepted");
  property p_tdo_off;
    @(posedge hclk) disable iff (!hresetn) !isc_active |=> !tdo_oe;
  endproperty
  a_tdo_off: assert property (p_tdo_off) else $error("data output driven before enable");
endmodule : jis_status_security
`default_nettype wire

/* tb/jis_jtag_ctrl.sv */
// Purpose: behavioural serial test controller for the status and security block
// Assumes: tck stands low between frames, half period 80 ns, tap starts in idle after treset
// Notes: a released tdo reads as a level that flips on every tck
`timescale 1ns/1ps
`default_nettype none
module jis_jtag_ctrl
  import jis_pkg::*;
(
  // frame alignment
  input wire logic hclk,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  logic last = 1'b0;
  logic lvl;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  assign lvl = tdo_oe ? tdo_o : ~last;
  always @(posedge tck) begin
    last <= lvl;
  end
  // one tck period, tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80;
    tck = 1'b1;
    o = lvl;
    #80;
    tck = 1'b0;
  endtask : step
  task automatic start();
    @(posedge hclk);
    #3;
  endtask : start
  task automatic treset();
    logic o;
    start();
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : treset
  // instruction scan, lsb first, back to idle
  task automatic ir(input logic [7:0] code);
    logic o;
    start();
    step(1'b1, 1'b0, o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < 8; i++) step(i == 7, code[i], o);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : ir
  // data scan, lsb first; last step leaves update
  task automatic dr(input logic [15:0] din, output logic [15:0] dout);
    logic o;
    start();
    step(1'b1, 1'b0, dout[0]);
    step(1'b0, 1'b0, dout[0]);
    step(1'b0, 1'b0, dout[0]);
    for (int i = 0; i < 16; i++) step(i == 15, din[i], dout[i]);
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : dr
  // enable with pin option
  task automatic enable(input logic od);
    logic [15:0] o;
    ir(JIS_IR_CONFIG_ENABLE);
    dr({14'h0000, od, 1'b1}, o);
  endtask : enable
endmodule : jis_jtag_ctrl
`default_nettype wire

/* tb/tb_jis_status_security.sv */
// Purpose: self-checking bench of the test-port status and security block
// Assumes: flash side modelled here with a fixed 20-cycle operation
// Notes: expected reads and flash requests are queued and checked by monitors
`timescale 1ns/1ps
`default_nettype none
module tb_jis_status_security
  import jis_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rd_dp, err_next;
  logic tck, tms, tdi, tdo_o, tdo_oe, chip_reset_n, flash_req_valid;
  logic rb_o, rb_oe, er_o, er_oe, flash_busy, flash_sec_write, flash_done, flash_error;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] flash_rdata, d, dat;
  jis_flash_req_type flash_req;
  int num_errors, n_tests, bcnt, seed;
  logic [31:0] rq[$];
  jis_flash_req_type fq[$];
  logic [7:0] codes [3] = '{JIS_IR_PROGRAM, JIS_IR_SECTOR_ERASE, JIS_IR_VERIFY};

  jis_status_security #(.NUM_SECTORS(8), .DR_W(16)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .isc_ready_busy_pin_o(rb_o), .isc_ready_busy_pin_oe(rb_oe),
    .isc_error_pin_o(er_o), .isc_error_pin_oe(er_oe), .chip_reset_n(chip_reset_n),
    .flash_req_valid(flash_req_valid), .flash_req(flash_req), .flash_busy(flash_busy),
    .flash_sec_write(flash_sec_write), .flash_done(flash_done), .flash_error(flash_error),
    .flash_rdata(flash_rdata));
  jis_jtag_ctrl u_jtag (.hclk(hclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

  always #5 hclk = ~hclk;

  // flash controller model
  always @(posedge hclk) begin
    if (!hresetn) begin
      flash_busy <= 1'b0;
      flash_done <= 1'b0;
      flash_error <= 1'b0;
      flash_rdata <= 16'h0000;
      bcnt <= 0;
    end else begin
      flash_done <= 1'b0;
      flash_error <= 1'b0;
      if (flash_req_valid === 1'b1) begin
        flash_busy <= 1'b1;
        flash_rdata <= 16'($random(seed));
        bcnt <= 20;
      end else if (bcnt == 1) begin
        flash_busy <= 1'b0;
        flash_done <= 1'b1;
        flash_error <= err_next;
        bcnt <= 0;
      end else if (bcnt > 0) begin
        bcnt <= bcnt - 1;
      end
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_req(input jis_flash_req_type got, input jis_flash_req_type exp);
    jis_flash_req_type g;
    g = got;
    if (exp.op !== JIS_OP_SECTOR_ERASE) g.sector = exp.sector;
    if (exp.op !== JIS_OP_PROGRAM) g.data = exp.data;
    chk_word({9'h000, g}, {9'h000, exp});
  endtask : chk_req
  task automatic pins(input logic [3:0] e);
    chk_word({28'h0000000, rb_o, rb_oe, er_o, er_oe}, {28'h0000000, e});
  endtask : pins
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task automatic wait_idle();
    int i;
    i = 0;
    while (flash_busy !== 1'b0 && i < 200) begin
      @(posedge hclk);
      i++;
    end
    wt(4);
  endtask : wait_idle
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dv, input logic [31:0] e);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    if (!w) rq.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= dv;
    rd_dp <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk_word({31'h0, hresp}, 32'h0);
    rd_dp <= 1'b0;
  endtask : ahb
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // read data and flash request monitors
  always @(posedge hclk) begin
    if (rd_dp === 1'b1 && hreadyout === 1'b1) chk_word(hrdata, rq.pop_front());
    if (flash_req_valid === 1'b1) begin
      if (fq.size() == 0) chk_word({9'h000, flash_req}, 32'hFFFFFFFF);
      else chk_req(flash_req, fq.pop_front());
    end
  end

  initial begin
    #500000;
    num_errors++;
    stop_test();
  end

  initial begin
    hclk = 1'b0;
    seed = 32'hf1446425;
    {hresetn, hsel, hwrite, rd_dp, err_next, flash_sec_write} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    chip_reset_n = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    pins(4'b0000);
    chk_word({31'h0, tdo_oe}, 32'h0);
    ahb(1'b0, JIS_OFS_SECURE, 32'h0, 32'h0);
    ahb(1'b0, JIS_OFS_PROT, 32'h0, JIS_RST_PROT);
    ahb(1'b0, JIS_OFS_IRQ_MASK, 32'h0, 32'h0);
    ahb(1'b1, 8'h40, 32'hFFFFFFFF, 32'h0);
    ahb(1'b0, 8'h40, 32'h0, 32'h0);
    u_jtag.treset();
    u_jtag.ir(JIS_IR_PROGRAM);
    u_jtag.dr(16'h1234, d);
    wt(4);
    chk_word({31'h0, irq}, 32'h0);
    ahb(1'b1, JIS_OFS_IRQ_MASK, 32'hF, 32'h0);
    wt(2);
    chk_word({31'h0, irq}, 32'h1);
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'h2);
    wt(2);
    chk_word({31'h0, irq}, 32'h0);
    u_jtag.enable(1'b0);
    wt(10);
    pins(4'b1111);
    dat = $random(seed);
    fq.push_back('{JIS_OP_PROGRAM, dat[4:0], dat});
    u_jtag.ir(JIS_IR_PROGRAM);
    u_jtag.dr(dat, d);
    chk_word({27'h0, d[4:0]}, 32'h01);
    wt(2);
    pins(4'b0111);
    wait_idle();
    pins(4'b1111);
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'h8);
    flash_sec_write <= 1'b1;
    wt(4);
    pins(4'b0111);
    flash_sec_write <= 1'b0;
    wt(4);
    pins(4'b1111);
    u_jtag.ir(JIS_IR_VERIFY);
    u_jtag.dr(16'h0000, d);
    chk_word({16'h0, d}, {16'h0, flash_rdata});
    err_next = 1'b1;
    fq.push_back('{JIS_OP_SECTOR_ERASE, 5'h03, 16'h0003});
    u_jtag.ir(JIS_IR_SECTOR_ERASE);
    u_jtag.dr(16'h0003, d);
    wait_idle();
    err_next = 1'b0;
    pins(4'b1101);
    wt(50);
    pins(4'b1101);
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'h9);
    u_jtag.ir(JIS_IR_ERROR_CLEAR);
    u_jtag.dr(16'h0000, d);
    wt(8);
    pins(4'b1111);
    u_jtag.enable(1'b1);
    wt(10);
    pins(4'b0000);
    err_next = 1'b1;
    fq.push_back('{JIS_OP_SECTOR_ERASE, 5'h04, 16'h0004});
    u_jtag.ir(JIS_IR_SECTOR_ERASE);
    u_jtag.dr(16'h0004, d);
    wt(2);
    pins(4'b0100);
    wait_idle();
    err_next = 1'b0;
    pins(4'b0001);
    u_jtag.ir(JIS_IR_CONFIG_DISABLE);
    u_jtag.dr(16'h0000, d);
    wt(8);
    pins(4'b0000);
    ahb(1'b0, JIS_OFS_STATUS, 32'h0, 32'h06);
    chip_reset_n <= 1'b0;
    wt(4);
    chip_reset_n <= 1'b1;
    wt(6);
    ahb(1'b0, JIS_OFS_STATUS, 32'h0, 32'h02);
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'h9);
    u_jtag.enable(1'b0);
    ahb(1'b1, JIS_OFS_PROT, 32'h4, 32'h0);
    ahb(1'b0, JIS_OFS_PROT, 32'h0, 32'h4);
    u_jtag.ir(JIS_IR_SECTOR_ERASE);
    u_jtag.dr(16'h0002, d);
    u_jtag.dr(16'h0008, d);
    fq.push_back('{JIS_OP_SECTOR_ERASE, 5'h03, 16'h0003});
    u_jtag.dr(16'h0003, d);
    wait_idle();
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'hA);
    ahb(1'b1, JIS_OFS_SECURE, 32'h1, 32'h0);
    ahb(1'b0, JIS_OFS_STATUS, 32'h0, 32'h11);
    foreach (codes[i]) begin
      u_jtag.ir(codes[i]);
      u_jtag.dr(16'h0001, d);
      if (codes[i] == JIS_IR_VERIFY) chk_word({16'h0, d}, 32'h0);
    end
    wt(4);
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'h2);
    fq.push_back('{JIS_OP_CHIP_ERASE, 5'h00, 16'h0000});
    u_jtag.ir(JIS_IR_CHIP_ERASE);
    u_jtag.dr(16'h0000, d);
    wait_idle();
    ahb(1'b0, JIS_OFS_SECURE, 32'h0, 32'h0);
    ahb(1'b0, JIS_OFS_PROT, 32'h0, 32'h0);
    ahb(1'b0, JIS_OFS_IRQ_STAT, 32'h0, 32'hC);
    chk_word(fq.size(), 32'h0);
    stop_test();
  end
endmodule : tb_jis_status_security
`default_nettype wire
